// ### common/rtc_defines.vh
// Register offsets, field positions and reset values of the calendar counter
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// Register byte offsets; channel fields as word indices
`define OFS_CTRL          12'h000
`define OFS_PRESCALE      12'h004
`define OFS_COUNT         12'h008
`define OFS_TIME          12'h010
`define OFS_DATE          12'h014
`define OFS_MATCH_FLAGS   12'h018
`define OFS_MATCH_CLEAR   12'h020
`define OFS_CH_BASE       12'h040
`define OFS_CH_STRIDE     12'h010
`define OFS_CH_CTRL       2'h0
`define OFS_CH_VALUE      2'h1
`define OFS_CH_TIME       2'h2
`define OFS_CH_DATE       2'h3

// Control register fields
`define CTRL_ENABLE       0
`define CTRL_CH1_TOP      5
`define CTRL_DIV_LO       8
`define CTRL_DIV_HI       11
`define CTRL_TICK_SRC     12
`define CTRL_MODE         16
`define CTRL_LEAP_DIS     17
`define CTRL_RESET        32'h0000_0000

// Channel control fields
`define CH_MODE_LO        0
`define CH_MODE_HI        1
`define CH_ACT_LO         2
`define CH_ACT_HI         3
`define CH_EDGE_LO        4
`define CH_EDGE_HI        5
`define CH_SEL_LO         6
`define CH_SEL_HI         8
`define CH_BASE           11
`define CH_MASK_LO        12
`define CH_MASK_HI        16
`define CH_DAY_SEL        17
`define CH_CTRL_RESET     32'h0000_0000

// Channel modes
`define CH_MODE_OFF       2'h0
`define CH_MODE_CAPTURE   2'h1
`define CH_MODE_COMPARE   2'h2

// Match output actions
`define ACT_PULSE         2'h0
`define ACT_TOGGLE        2'h1
`define ACT_CLEAR         2'h2
`define ACT_SET           2'h3

// Capture edges
`define EDGE_RISING       2'h0
`define EDGE_FALLING      2'h1
`define EDGE_BOTH         2'h2

// Calendar reset values: 00:00:00, day 1, January, year 00
`define TIME_RESET        32'h0000_0000
`define DATE_RESET        32'h0000_0101
`define COUNT_RESET       32'h0000_0000
`define PRESCALE_RESET    15'h0000

`endif

// ### core/rtc_calendar_counter.v
// Real-time counter with BCD calendar, APB registers and three channels
`timescale 1ns/1ps
`include "rtc_defines.vh"

// What this block does
// - Pre-counter advances per slow clock rising edge, wraps
// - Mode bit picks binary or BCD calendar
// - Calendar-only registers ignore writes in binary mode
// - Tap mode ticks from power-of-two pre-counter tap
// - Channel 0 value tops pre-counter and ticks
// - Main counter wraps at all-ones by default
// - Channel-1 top option wraps count at match
// - Time and date registers show BCD calendar
// - Month lengths 28, 29, 30, 31 handled
// - Three-bit weekday advances at midnight, wraps seven
// - Leap correction on unless disable bit set
// - Seconds, minutes, hours in 24-hour BCD
// - Month is one tens bit, four units bits
// - Counters writable any time; prescale write shifts ticks
// - Three channels, each capture or compare
// - Capture copies count or calendar on event edge
// - Compare subject follows mode and compare base
// - Calendar day compares month day or weekday
// - Mask width drops low bits from compare
// - Match sets flag and drives event output
module rtc_calendar_counter #(
  parameter EVT_W = 8
) (
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire             low_freq_clock,
  input  wire [EVT_W-1:0] event_in,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  output reg  [2:0]       match_event,
  output reg  [2:0]       match_flags
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function is_leap;
    input [3:0] tens;
    input [3:0] units;
    begin
      if (!tens[0])
        is_leap = (units[1:0] == 2'h0);
      else
        is_leap = (units[1:0] == 2'h2);
    end
  endfunction

  // Last day of the month as two BCD digits
  function [5:0] last_day;
    input       mon_t;
    input [3:0] mon_u;
    input       leap;
    begin
      if (mon_t)
        last_day = (mon_u == 4'h1) ? 6'h30 : 6'h31;
      else if (mon_u == 4'h2)
        last_day = leap ? 6'h29 : 6'h28;
      else if (mon_u == 4'h4 || mon_u == 4'h6 || mon_u == 4'h9)
        last_day = 6'h30;
      else
        last_day = 6'h31;
    end
  endfunction

  // Bits kept by a compare mask of the given width
  function [31:0] keep_mask;
    input [4:0] width;
    begin
      keep_mask = 32'hFFFF_FFFF << width;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for the slow clock and event inputs

  reg             lf_meta_reg;
  reg             lf_sync_reg;
  reg             lf_prev_reg;
  reg [EVT_W-1:0] evt_meta_reg;
  reg [EVT_W-1:0] evt_sync_reg;
  reg [EVT_W-1:0] evt_prev_reg;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lf_meta_reg  <= 1'b0;
      lf_sync_reg  <= 1'b0;
      lf_prev_reg  <= 1'b0;
      evt_meta_reg <= {EVT_W{1'b0}};
      evt_sync_reg <= {EVT_W{1'b0}};
      evt_prev_reg <= {EVT_W{1'b0}};
    end else begin
      lf_meta_reg  <= low_freq_clock;
      lf_sync_reg  <= lf_meta_reg;
      lf_prev_reg  <= lf_sync_reg;
      evt_meta_reg <= event_in;
      evt_sync_reg <= evt_meta_reg;
      evt_prev_reg <= evt_sync_reg;
    end
  end

  wire lf_edge = lf_sync_reg & ~lf_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // Register state

  reg [31:0] ctrl_reg;
  reg [14:0] prescale_count;
  reg [31:0] count_reg;
  reg [31:0] time_reg;
  reg [31:0] date_reg;
  reg [31:0] ch_ctrl_reg  [0:2];
  reg [31:0] channel_compare_value [0:2];
  reg [31:0] channel_time_value    [0:2];
  reg [31:0] channel_date_value    [0:2];
  reg [2:0]  eq_prev_reg;

  wire        enable             = ctrl_reg[`CTRL_ENABLE];
  wire        channel1_top_wrap  = ctrl_reg[`CTRL_CH1_TOP];
  wire [3:0]  tick_divider       = ctrl_reg[`CTRL_DIV_HI:`CTRL_DIV_LO];
  wire        tick_source_select = ctrl_reg[`CTRL_TICK_SRC];
  wire        main_counter_mode  = ctrl_reg[`CTRL_MODE];
  wire        leap_correction_disable = ctrl_reg[`CTRL_LEAP_DIS];

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire        bus_done   = psel & penable & pready;
  wire        bus_wr     = bus_done & pwrite;
  wire        in_ch      = paddr[11:4] >= 8'h04 && paddr[11:4] <= 8'h06;
  wire [1:0]  ch_idx     = paddr[5:4];
  wire [1:0]  ch_field   = paddr[3:2];
  wire        word_ok    = paddr[1:0] == 2'h0;
  wire        wr_ctrl    = bus_wr && paddr == `OFS_CTRL;
  wire        wr_pre     = bus_wr && paddr == `OFS_PRESCALE;
  wire        wr_count   = bus_wr && paddr == `OFS_COUNT;
  wire        wr_time    = bus_wr && paddr == `OFS_TIME &&
                           main_counter_mode;
  wire        wr_date    = bus_wr && paddr == `OFS_DATE &&
                           main_counter_mode;
  wire        wr_clear   = bus_wr && paddr == `OFS_MATCH_CLEAR;
  wire        wr_ch      = bus_wr && in_ch && word_ok;

  ////////////////////////////////////////////////////////////////////////
  // Tick generation

  wire [14:0] tap_mask  = ~(15'h7FFF << tick_divider);
  wire        top_hit   = prescale_count == channel_compare_value[0][14:0];
  wire        tap_tick  = (prescale_count & tap_mask) == tap_mask;
  wire        slow_step = enable & lf_edge;
  wire        main_tick = slow_step &
                          (tick_source_select ? top_hit : tap_tick);

  // Pre-counter; a software write wins over counting and moves tick phase
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      prescale_count <= `PRESCALE_RESET;
    else if (wr_pre)
      prescale_count <= pwdata[14:0];
    else if (slow_step && tick_source_select && top_hit)
      prescale_count <= 15'h0000;
    else if (slow_step)
      prescale_count <= prescale_count + 15'h0001;
  end

  // Binary main counter
  wire ch1_top = channel1_top_wrap &&
                 count_reg == channel_compare_value[1];

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      count_reg <= `COUNT_RESET;
    else if (wr_count)
      count_reg <= pwdata;
    else if (main_tick && !main_counter_mode) begin
      // Past the channel-1 value the wrap falls back to all-ones
      if (ch1_top)
        count_reg <= 32'h0000_0000;
      else
        count_reg <= count_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // BCD calendar

  wire [3:0] sec_u  = time_reg[3:0];
  wire [2:0] sec_t  = time_reg[6:4];
  wire [3:0] min_u  = time_reg[11:8];
  wire [2:0] min_t  = time_reg[14:12];
  wire [3:0] hour_u = time_reg[19:16];
  wire [1:0] hour_tens = time_reg[21:20];
  wire [5:0] month_day   = date_reg[5:0];
  wire [3:0] month_units = date_reg[11:8];
  wire       month_tens  = date_reg[12];
  wire [3:0] year_units  = date_reg[19:16];
  wire [3:0] year_tens   = date_reg[23:20];
  wire [2:0] weekday_count = date_reg[26:24];

  wire leap = ~leap_correction_disable &
              is_leap(year_tens, year_units);
  wire [5:0] month_end = last_day(month_tens, month_units, leap);

  wire sec_wrap  = sec_u == 4'h9 && sec_t == 3'h5;
  wire min_wrap  = sec_wrap && min_u == 4'h9 && min_t == 3'h5;
  wire hour_wrap = min_wrap && hour_u == 4'h3 && hour_tens == 2'h2;
  wire mon_wrap  = hour_wrap && month_day == month_end;
  wire year_wrap = mon_wrap && month_tens && month_units == 4'h2;

  reg [31:0] time_next;
  reg [31:0] date_next;

  always @* begin
    time_next = time_reg;
    date_next = date_reg;
    // 24-hour clock, BCD digits
    time_next[3:0] = (sec_u == 4'h9) ? 4'h0 : sec_u + 4'h1;
    if (sec_u == 4'h9)
      time_next[6:4] = (sec_t == 3'h5) ? 3'h0 : sec_t + 3'h1;
    if (sec_wrap) begin
      time_next[11:8] = (min_u == 4'h9) ? 4'h0 : min_u + 4'h1;
      if (min_u == 4'h9)
        time_next[14:12] = (min_t == 3'h5) ? 3'h0 : min_t + 3'h1;
    end
    if (min_wrap) begin
      if (hour_wrap)
        time_next[21:16] = 6'h00;
      else if (hour_u == 4'h9)
        time_next[21:16] = {hour_tens + 2'h1, 4'h0};
      else
        time_next[19:16] = hour_u + 4'h1;
    end
    if (hour_wrap) begin
      date_next[26:24] = (weekday_count == 3'h6) ? 3'h0 :
                         weekday_count + 3'h1;
      if (mon_wrap)
        date_next[5:0] = 6'h01;
      else if (month_day[3:0] == 4'h9)
        date_next[5:0] = {month_day[5:4] + 2'h1, 4'h0};
      else
        date_next[3:0] = month_day[3:0] + 4'h1;
    end
    if (mon_wrap) begin
      if (year_wrap)
        date_next[12:8] = 5'h01;
      else if (month_units == 4'h9)
        date_next[12:8] = 5'h10;
      else
        date_next[11:8] = month_units + 4'h1;
    end
    if (year_wrap) begin
      if (year_units == 4'h9) begin
        date_next[19:16] = 4'h0;
        date_next[23:20] = (year_tens == 4'h9) ? 4'h0 : year_tens + 4'h1;
      end else
        date_next[19:16] = year_units + 4'h1;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      time_reg <= `TIME_RESET;
      date_reg <= `DATE_RESET;
    end else begin
      if (wr_time)
        time_reg <= pwdata;
      else if (main_tick && main_counter_mode)
        time_reg <= time_next;
      if (wr_date)
        date_reg <= pwdata;
      else if (main_tick && main_counter_mode)
        date_reg <= date_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture / compare channels

  reg [2:0]  eq_now;
  reg [2:0]  capture_hit;
  reg [31:0] live_vec;
  reg [31:0] ref_vec;
  reg [31:0] ccfg;
  reg [5:0]  day_live;
  reg        evt_now;
  reg        evt_was;
  integer    i;

  always @* begin
    eq_now      = 3'h0;
    capture_hit = 3'h0;
    live_vec    = 32'h0000_0000;
    ref_vec     = 32'h0000_0000;
    ccfg        = 32'h0000_0000;
    day_live    = 6'h00;
    evt_now     = 1'b0;
    evt_was     = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      ccfg = ch_ctrl_reg[i];
      day_live = ccfg[`CH_DAY_SEL] ? {3'h0, weekday_count} :
                 month_day;
      if (!main_counter_mode && !ccfg[`CH_BASE]) begin
        live_vec = count_reg;
        ref_vec  = channel_compare_value[i];
      end else if (!main_counter_mode) begin
        live_vec = {count_reg[16:0], prescale_count};
        ref_vec  = channel_compare_value[i];
      end else if (ccfg[`CH_BASE]) begin
        live_vec = {17'h00000, prescale_count};
        ref_vec  = {17'h00000, channel_compare_value[i][14:0]};
      end else begin
        // Month, day, hour, minute, second from most to least weight
        live_vec = {1'b0, date_reg[12:8], day_live,
                    time_reg[21:16], time_reg[14:8], time_reg[6:0]};
        ref_vec  = {1'b0, channel_date_value[i][12:8],
                    channel_date_value[i][5:0],
                    channel_time_value[i][21:16],
                    channel_time_value[i][14:8],
                    channel_time_value[i][6:0]};
      end
      eq_now[i] = ccfg[`CH_MODE_HI:`CH_MODE_LO] == `CH_MODE_COMPARE &&
                  ((live_vec ^ ref_vec) &
                   keep_mask(ccfg[`CH_MASK_HI:`CH_MASK_LO])) ==
                  32'h0000_0000;
      evt_now = evt_sync_reg[ccfg[`CH_SEL_HI:`CH_SEL_LO]];
      evt_was = evt_prev_reg[ccfg[`CH_SEL_HI:`CH_SEL_LO]];
      if (ccfg[`CH_MODE_HI:`CH_MODE_LO] == `CH_MODE_CAPTURE) begin
        case (ccfg[`CH_EDGE_HI:`CH_EDGE_LO])
          `EDGE_RISING:  capture_hit[i] = evt_now & ~evt_was;
          `EDGE_FALLING: capture_hit[i] = ~evt_now & evt_was;
          `EDGE_BOTH:    capture_hit[i] = evt_now ^ evt_was;
          default:       capture_hit[i] = 1'b0;
        endcase
      end
    end
  end

  // Only a rising equality counts, so a held match fires once
  wire [2:0] match_hit = eq_now & ~eq_prev_reg;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 3; i = i + 1) begin
        ch_ctrl_reg[i]           <= `CH_CTRL_RESET;
        channel_compare_value[i] <= 32'h0000_0000;
        channel_time_value[i]    <= `TIME_RESET;
        channel_date_value[i]    <= `DATE_RESET;
      end
      eq_prev_reg <= 3'h0;
      match_event <= 3'h0;
      match_flags <= 3'h0;
    end else begin
      eq_prev_reg <= eq_now;
      for (i = 0; i < 3; i = i + 1) begin
        if (wr_ch && ch_idx == i && ch_field == `OFS_CH_CTRL)
          ch_ctrl_reg[i] <= pwdata;
        if (capture_hit[i] && !main_counter_mode)
          channel_compare_value[i] <= count_reg;
        else if (wr_ch && ch_idx == i && ch_field == `OFS_CH_VALUE)
          channel_compare_value[i] <= pwdata;
        if (capture_hit[i] && main_counter_mode) begin
          channel_time_value[i] <= time_reg;
          channel_date_value[i] <= date_reg;
        end else if (wr_ch && ch_idx == i && main_counter_mode) begin
          if (ch_field == `OFS_CH_TIME)
            channel_time_value[i] <= pwdata;
          if (ch_field == `OFS_CH_DATE)
            channel_date_value[i] <= pwdata;
        end
        // Set wins over a simultaneous clear
        if (match_hit[i])
          match_flags[i] <= 1'b1;
        else if (wr_clear && pwdata[i])
          match_flags[i] <= 1'b0;
        case (ch_ctrl_reg[i][`CH_ACT_HI:`CH_ACT_LO])
          `ACT_PULSE:  match_event[i] <= match_hit[i];
          `ACT_TOGGLE: match_event[i] <= match_event[i] ^ match_hit[i];
          `ACT_CLEAR:  match_event[i] <= match_event[i] & ~match_hit[i];
          `ACT_SET:    match_event[i] <= match_event[i] | match_hit[i];
          default:     match_event[i] <= match_event[i];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register and APB answer

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      ctrl_reg <= `CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= pwdata & 32'h0003_1F21;
  end

  reg [31:0] rd_data;
  reg        rd_ok;

  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (in_ch && word_ok) begin
      case (ch_field)
        `OFS_CH_CTRL:  rd_data = ch_ctrl_reg[ch_idx];
        `OFS_CH_VALUE: rd_data = channel_compare_value[ch_idx];
        `OFS_CH_TIME:  rd_data = channel_time_value[ch_idx];
        default:       rd_data = channel_date_value[ch_idx];
      endcase
    end else begin
      case (paddr)
        `OFS_CTRL:        rd_data = ctrl_reg;
        `OFS_PRESCALE:    rd_data = {17'h00000, prescale_count};
        `OFS_COUNT:       rd_data = count_reg;
        `OFS_TIME:        rd_data = time_reg;
        `OFS_DATE:        rd_data = date_reg;
        `OFS_MATCH_FLAGS: rd_data = {29'h0000_0000, match_flags};
        `OFS_MATCH_CLEAR: rd_data = 32'h0000_0000;
        default:          rd_ok   = 1'b0;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_data :
                 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~rd_ok;
    end
  end

endmodule

// ### dv/rtc_calendar_counter_checker.sv
// Port-level assertions for the calendar counter
`timescale 1ns/1ps
`include "rtc_defines.vh"
module rtc_calendar_counter_checker #(
  parameter EVT_W = 8
) (
  input wire             ref_clk,
  input wire             nrst,
  input wire             low_freq_clock,
  input wire [EVT_W-1:0] event_in,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [11:0]      paddr,
  input wire [31:0]      pwdata,
  input wire [31:0]      prdata,
  input wire             pready,
  input wire             pslverr,
  input wire [2:0]       match_event,
  input wire [2:0]       match_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_ready_latency: assert property (psel && !penable |-> ##2 pready)
    else $error("access not answered on its second cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (
    pready && paddr[11:8] != 4'h0 |-> pslverr)
    else $error("unmapped address answered without error");
  a_rdata_idle: assert property (
    !(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data driven outside a read answer");
  // Sticky flags may only drop through the clear register
  a_flag_clear: assert property (
    |($past(match_flags) & ~match_flags) |->
      $past(pready && pwrite && paddr == `OFS_MATCH_CLEAR))
    else $error("match flag dropped without a clear write");
  a_event_flag: assert property (
    (match_event & ~$past(match_event) & ~match_flags) == 3'h0)
    else $error("event output rose without its match flag");

  c_error: cover property (pslverr);
  c_flag: cover property ($rose(match_flags[0]));
  c_event: cover property ($rose(match_event[0]));
endmodule

bind rtc_calendar_counter rtc_calendar_counter_checker #(.EVT_W(EVT_W)) u_chk (
  .ref_clk, .nrst, .low_freq_clock, .event_in, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .match_event, .match_flags);

// ### dv/tb.sv
// Self-checking bench for the calendar counter
`timescale 1ns/1ps
`include "rtc_defines.vh"
module tb;
  logic        ref_clk;
  logic        nrst;
  logic        low_freq_clock;
  logic [7:0]  event_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [2:0]  match_event;
  wire  [2:0]  match_flags;
  integer      mismatches;
  integer      compares;
  logic [31:0] q;
  logic        e;
  integer      i, n, dv, c, s;
  logic [31:0] tab [8];
  localparam logic [11:0] CH1 = 12'h050;
  localparam logic [11:0] CH2 = 12'h060;

  rtc_calendar_counter #(.EVT_W(8)) u_dut (
    .ref_clk, .nrst, .low_freq_clock, .event_in, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .match_event, .match_flags);

  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares = compares + 1;
    if (got !== ex) begin
      mismatches = mismatches + 1;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Request held until pready is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k = k + 1;
    end while (pready !== 1'h1 && k < 40);
    if (pready !== 1'h1) begin
      mismatches = mismatches + 1;
      conclude;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task rd(input logic [11:0] a);
    xfer(1'h0, a, 32'h0);
  endtask

  // Slow clock held at each level for four fast cycles
  task steps(input integer k);
    repeat (k) begin
      low_freq_clock <= 1'h1;
      repeat (4) @(posedge ref_clk);
      low_freq_clock <= 1'h0;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  // Next calendar date after midnight
  function automatic logic [31:0] nxt(input logic [31:0] d, input logic ld);
    integer dy, mo, yr, md, yu;
    dy = d[5:4] * 10 + d[3:0];
    mo = d[12] * 10 + d[11:8];
    yr = d[23:20] * 10 + d[19:16];
    yu = d[19:16];
    md = (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
    if (mo == 2)
      md = (!ld && (d[20] ? (yu + 2) % 4 == 0 : yu % 4 == 0)) ? 29 : 28;
    if (dy < md) dy = dy + 1;
    else begin
      dy = 1;
      if (mo < 12) mo = mo + 1;
      else begin
        mo = 1;
        yr = (yr + 1) % 100;
      end
    end
    return {5'h0, (d[26:24] == 3'h6) ? 3'h0 : d[26:24] + 3'h1,
            4'(yr / 10), 4'(yr % 10), 3'h0, 1'(mo / 10), 4'(mo % 10),
            2'h0, 2'(dy / 10), 4'(dy % 10)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    s = $urandom(32'hEC20D53C);
    {nrst, low_freq_clock, psel, penable, pwrite} = 5'h0;
    event_in = 8'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    mismatches = 0;
    compares = 0;
    tab = '{32'h0624_0228, 32'h0024_0229, 32'h0224_0228, 32'h0312_0228,
            32'h0413_0228, 32'h0523_0430, 32'h0123_1231, 32'h0023_0930};
    repeat (5) @(posedge ref_clk);
    nrst <= 1'h1;
    @(posedge ref_clk);
    rd(`OFS_CTRL);
    chk("ctrl", `CTRL_RESET, q);
    rd(`OFS_DATE);
    chk("date", `DATE_RESET, q);
    rd(12'h1FC);
    chk("unmapped", 32'h1, {31'h0, e});
    wr(`OFS_TIME, 32'h0012_3456);
    rd(`OFS_TIME);
    chk("time", `TIME_RESET, q);
    rd(CH1 + 12'h00C);
    c = q;
    wr(CH1 + 12'h00C, 32'h0000_1215);
    rd(CH1 + 12'h00C);
    chk("chan date", c, q);
    for (i = 0; i < 3; i++) begin
      dv = $urandom % 4;
      n = 1 + $urandom % 40;
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_PRESCALE, 32'h0);
      wr(`OFS_COUNT, 32'h0);
      wr(`OFS_CTRL, 32'h1 | (dv << `CTRL_DIV_LO));
      steps(n);
      rd(`OFS_PRESCALE);
      chk("prescale", n, q);
      rd(`OFS_COUNT);
      chk("count", n >> dv, q);
    end
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_PRESCALE, 32'h0000_7FFE);
    wr(`OFS_CTRL, 32'h0000_0F01);
    steps(3);
    rd(`OFS_PRESCALE);
    chk("prescale wrap", 32'h1, q);
    rd(`OFS_COUNT);
    chk("count div32768", (n >> dv) + 1, q);
    dv = 1 + $urandom % 7;
    n = 1 + $urandom % 30;
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_PRESCALE, 32'h0);
    wr(`OFS_COUNT, 32'h0);
    wr(`OFS_CH_BASE + 12'h004, dv);
    wr(`OFS_CTRL, 32'h0000_1001);
    steps(n);
    rd(`OFS_COUNT);
    chk("top count", n / (dv + 1), q);
    rd(`OFS_PRESCALE);
    chk("top prescale", n % (dv + 1), q);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_COUNT, 32'hFFFF_FFFF);
    wr(`OFS_CTRL, 32'h1);
    steps(2);
    rd(`OFS_COUNT);
    chk("count wrap", 32'h1, q);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_COUNT, 32'h0);
    wr(CH1 + 12'h004, 32'h5);
    wr(CH1, {30'h0, `CH_MODE_COMPARE});
    wr(`OFS_CTRL, 32'h21);
    steps(8);
    rd(`OFS_COUNT);
    chk("ch1 wrap", 32'h2, q);
    chk("ch1 flag", 32'h1, {31'h0, match_flags[1]});
    wr(CH1, 32'h0);
    wr(`OFS_CTRL, 32'h1);
    steps(1);
    rd(`OFS_COUNT);
    chk("flush tick", 32'h3, q);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_MATCH_CLEAR, 32'h7);
    wr(`OFS_COUNT, 32'h0E);
    wr(`OFS_CH_BASE + 12'h004, 32'h13);
    wr(`OFS_CH_BASE, 32'h0000_200E);
    wr(`OFS_CTRL, 32'h1);
    steps(1);
    chk("mask early", 32'h0, {31'h0, match_flags[0]});
    steps(1);
    chk("mask flag", 32'h1, {31'h0, match_flags[0]});
    chk("set action", 32'h1, {31'h0, match_event[0]});
    wr(`OFS_MATCH_CLEAR, 32'h1);
    steps(1);
    chk("match once", 32'h0, {31'h0, match_flags[0]});
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_COUNT, 32'h1);
    wr(`OFS_PRESCALE, 32'h0);
    wr(CH2 + 12'h004, 32'h0000_8002);
    wr(CH2, 32'h0000_0802);
    wr(`OFS_CTRL, 32'h0000_0F01);
    steps(2);
    chk("prescale base", 32'h1, {31'h0, match_flags[2]});
    for (i = 0; i < 8; i++) begin
      c = (i == 2) ? 32'h0003_0F00 : 32'h0001_0F00;
      wr(`OFS_CTRL, c);
      wr(`OFS_TIME, 32'h0023_5959);
      wr(`OFS_DATE, tab[i]);
      wr(`OFS_PRESCALE, 32'h0000_7FFF);
      wr(`OFS_CTRL, c | 32'h1);
      steps(1);
      wr(`OFS_CTRL, c);
      rd(`OFS_TIME);
      chk("midnight", 32'h0, q);
      rd(`OFS_DATE);
      chk("next date", nxt(tab[i], i == 2), q);
    end
    // Weekday 1 in October after the last rollover
    wr(CH1 + 12'h008, 32'h0000_0001);
    wr(CH1 + 12'h00C, 32'h0000_1001);
    wr(CH1, 32'h0002_0006);
    wr(`OFS_PRESCALE, 32'h0000_7FFF);
    wr(`OFS_CTRL, c | 32'h1);
    steps(1);
    chk("weekday match", 32'h1, {31'h0, match_flags[1]});
    chk("toggle action", 32'h1, {31'h0, match_event[1]});
    c = $urandom;
    s = $urandom % 8;
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_COUNT, c);
    wr(CH2, 32'h1 | (s << `CH_SEL_LO));
    event_in[s] <= 1'h1;
    repeat (6) @(posedge ref_clk);
    rd(CH2 + 12'h004);
    chk("capture", c, q);
    wr(`OFS_COUNT, ~c);
    event_in[s] <= 1'h0;
    repeat (6) @(posedge ref_clk);
    rd(CH2 + 12'h004);
    chk("capture edge", c, q);
    conclude;
  end
endmodule
